/* rtl/pmbus_cmd_pkg.sv */
/*
 Command codes, fixed answers, field positions and reset values for the
 PMBus command decoder. Assumes one clock domain and no other users.
*/
package pmbus_cmd_pkg;
	// -----------------------------------------------------------------
	// Command codes
	// -----------------------------------------------------------------
	localparam logic [7:0] CMD_RUN = 8'h01;
	localparam logic [7:0] CMD_SRC = 8'h02;
	localparam logic [7:0] CMD_CLR = 8'h03;
	localparam logic [7:0] CMD_WP = 8'h10;
	localparam logic [7:0] CMD_SAVE = 8'h11;
	localparam logic [7:0] CMD_LOAD = 8'h12;
	localparam logic [7:0] CMD_FEAT = 8'h19;
	localparam logic [7:0] CMD_FMT = 8'h20;
	localparam logic [7:0] CMD_VSET = 8'h21;
	localparam logic [7:0] CMD_VHI = 8'h25;
	localparam logic [7:0] CMD_VLO = 8'h26;
	localparam logic [7:0] CMD_SBYTE = 8'h78;
	localparam logic [7:0] CMD_SWORD = 8'h79;
	localparam logic [7:0] CMD_SVOUT = 8'h7A;
	localparam logic [7:0] CMD_SIOUT = 8'h7B;
	localparam logic [7:0] CMD_SCML = 8'h7E;
	localparam logic [7:0] CMD_IDENT = 8'hFC;
	localparam int MFR_COUNT = 7;
	localparam logic [7:0] MFR_CODE [MFR_COUNT] = '{8'hD0, 8'hD1, 8'hD2,
		8'hD3, 8'hD4, 8'hD6, 8'hD7};

	// -----------------------------------------------------------------
	// Fixed answers and field layouts
	// -----------------------------------------------------------------
	localparam logic [7:0] FEATURE_VAL = 8'hD0;
	localparam logic [7:0] FORMAT_VAL = 8'h17;
	// Arbitrary identity value, not tied to any part
	localparam logic [15:0] IDENT_WORD = 16'h5A01;
	localparam logic [7:0] WP_ONLY_SELF = 8'h80;
	localparam logic [7:0] WP_PLUS_RUN = 8'h40;
	localparam logic [7:0] WP_PLUS_SETUP = 8'h20;
	localparam logic [7:0] WP_OPEN = 8'h00;
	localparam int RUN_ON_BIT = 7;
	localparam logic [7:0] RUN_FIXED_MASK = 8'h43;
	localparam logic [3:0] MRG_LO_IGN = 4'h5;
	localparam logic [3:0] MRG_LO_ACT = 4'h6;
	localparam logic [3:0] MRG_HI_IGN = 4'h9;
	localparam logic [3:0] MRG_HI_ACT = 4'hA;
	localparam logic [7:0] SRC_FIXED_MASK = 8'hF3;
	localparam logic [7:0] SRC_FIXED_VAL = 8'h13;
	localparam int SRC_CMD_BIT = 3;
	localparam int SRC_PIN_BIT = 2;
	localparam int SB_OFF = 6;
	localparam int SB_VOV = 5;
	localparam int SB_IOC = 4;
	localparam int SB_VDD = 3;
	localparam int SB_TEMP = 2;
	localparam int SB_CML = 1;
	localparam int SW_VOUT = 15;
	localparam int SW_IOUT = 14;
	localparam int SW_VDD = 13;
	localparam int SW_PGL = 11;
	localparam int CML_BADCMD = 7;
	localparam int CML_BADDATA = 6;
	localparam int CML_PEC = 5;
	localparam int VOUT_OVF = 7;
	localparam int IOUT_OCF = 7;

	// -----------------------------------------------------------------
	// Reset values
	// -----------------------------------------------------------------
	localparam logic [7:0] RUN_RST = 8'h00;
	localparam logic [7:0] SRC_RST = 8'h17;
	localparam logic [7:0] WP_RST = 8'h00;
	localparam logic [15:0] VSET_RST = 16'h0133;
	localparam logic [15:0] VHI_RST = 16'h0266;
	localparam logic [15:0] VLO_RST = 16'h0133;
	localparam logic [7:0] MFR_RST = 8'h00;

	// Access class of a command code
	typedef enum logic [5:0] {
		KIND_NONE = 6'b000001,
		KIND_BYTE_RW = 6'b000010,
		KIND_WORD_RW = 6'b000100,
		KIND_SEND = 6'b001000,
		KIND_BYTE_RO = 6'b010000,
		KIND_WORD_RO = 6'b100000
	} cmd_kind_e;
endpackage

/* rtl/pmbus_command_decoder.sv */
/*
 PMBus command decoder of a point-of-load converter: command registers,
 write protection, default store, status reporting and alert.
 Assumes a bus framer on mclk that hands over one finished transaction
 per strobe; the enable pin and fault flags come from other domains.
*/
`timescale 1ns/10ps
module pmbus_command_decoder (
	// Clock, reset, freeze
	input wire logic mclk,
	input wire logic srst,
	input wire logic clkEn,
	// Transaction from the bus framer
	input wire logic cmdStrobe,
	input wire logic cmdWrite,
	input wire logic [7:0] cmdCode,
	input wire logic [1:0] wrByteCnt,
	input wire logic [15:0] wrData,
	input wire logic pecChecked,
	input wire logic pecGood,
	// Read answer to the framer
	output logic rdValid,
	output logic rdAck,
	output logic [15:0] rdData,
	// Pins and fault sources from other domains
	input wire logic enPin,
	input wire logic [3:0] voutFaultEv,
	input wire logic [2:0] ioutFaultEv,
	input wire logic vddUvEv,
	input wire logic overTempEv,
	input wire logic power_good_lost_flag,
	// Alert pin, open drain
	output logic alertOut,
	output logic alertOe,
	// Converter controls
	output logic convOn,
	output logic [1:0] marginSel,
	output logic marginActOnFault,
	output logic [15:0] vrefTarget,
	output logic [7:0] delaySetting,
	output logic [7:0] freqSetting,
	output logic [7:0] lockoutSetting,
	output logic [7:0] loopOffsetSetting,
	output logic [7:0] trackSetting
);
	// -----------------------------------------------------------------
	// Input synchronisers
	// -----------------------------------------------------------------
	logic [11:1] syncA_r;
	logic [11:1] syncB_r;
	logic enPinS;
	logic [3:0] voutEvS;
	logic [2:0] ioutEvS;
	logic vddUvS;
	logic overTempS;
	logic pgLostS;

	// Two stages on every pin; only stage B is read by logic
	always_ff @(posedge mclk) begin
		if (srst) begin
			syncA_r <= 11'h000;
			syncB_r <= 11'h000;
		end else if (clkEn) begin
			syncA_r <= {enPin, voutFaultEv, ioutFaultEv, vddUvEv, overTempEv,
				power_good_lost_flag};
			syncB_r <= syncA_r;
		end
	end
	assign enPinS = syncB_r[11];
	assign voutEvS = syncB_r[10:7];
	assign ioutEvS = syncB_r[6:4];
	assign vddUvS = syncB_r[3];
	assign overTempS = syncB_r[2];
	assign pgLostS = syncB_r[1];

	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	logic [7:0] runReg_r;
	logic [7:0] srcReg_r;
	logic [7:0] wpReg_r;
	logic [15:0] vsetReg_r;
	logic [15:0] vhiReg_r;
	logic [15:0] vloReg_r;
	logic [7:0] mfrReg_r [pmbus_cmd_pkg::MFR_COUNT];
	logic [7:0] nvSrc_r;
	logic [7:0] nvWp_r;
	logic [15:0] nvVset_r;
	logic [7:0] nvMfr_r [pmbus_cmd_pkg::MFR_COUNT];
	logic [7:4] voutSt_r;
	logic [7:4] ioutSt_r;
	logic vddSt_r;
	logic tempSt_r;
	logic badCmd_r;
	logic badData_r;
	logic pecOk_r;

	// -----------------------------------------------------------------
	// Command decode
	// -----------------------------------------------------------------
	pmbus_cmd_pkg::cmd_kind_e kind;
	logic [pmbus_cmd_pkg::MFR_COUNT-1:0] mfrHit;
	logic wpAllows;
	logic dataOk;
	logic cntOk;
	logic pecFail;
	logic isWrite;
	logic doWrite;
	logic doClear;
	logic doSave;
	logic doLoad;
	logic wrongDir;

	// One match line per manufacturer byte
	genvar g;
	generate
		for (g = 0; g < pmbus_cmd_pkg::MFR_COUNT; g++) begin : gMfrHit
			assign mfrHit[g] = (cmdCode == pmbus_cmd_pkg::MFR_CODE[g]);
		end
	endgenerate

	// Access class of the code; unknown codes fall to none
	always_comb begin
		case (cmdCode)
			pmbus_cmd_pkg::CMD_RUN, pmbus_cmd_pkg::CMD_SRC,
			pmbus_cmd_pkg::CMD_WP: kind = pmbus_cmd_pkg::KIND_BYTE_RW;
			pmbus_cmd_pkg::CMD_VSET, pmbus_cmd_pkg::CMD_VHI,
			pmbus_cmd_pkg::CMD_VLO: kind = pmbus_cmd_pkg::KIND_WORD_RW;
			pmbus_cmd_pkg::CMD_CLR, pmbus_cmd_pkg::CMD_SAVE,
			pmbus_cmd_pkg::CMD_LOAD: kind = pmbus_cmd_pkg::KIND_SEND;
			pmbus_cmd_pkg::CMD_FEAT, pmbus_cmd_pkg::CMD_FMT,
			pmbus_cmd_pkg::CMD_SBYTE, pmbus_cmd_pkg::CMD_SVOUT,
			pmbus_cmd_pkg::CMD_SIOUT,
			pmbus_cmd_pkg::CMD_SCML: kind = pmbus_cmd_pkg::KIND_BYTE_RO;
			pmbus_cmd_pkg::CMD_SWORD,
			pmbus_cmd_pkg::CMD_IDENT: kind = pmbus_cmd_pkg::KIND_WORD_RO;
			default: kind = (|mfrHit) ? pmbus_cmd_pkg::KIND_BYTE_RW :
				pmbus_cmd_pkg::KIND_NONE;
		endcase
	end

	// Lock level decides which codes may be written; the lock itself
	// stays writable at every level so it is never permanent
	always_comb begin
		case (wpReg_r)
			pmbus_cmd_pkg::WP_ONLY_SELF:
				wpAllows = (cmdCode == pmbus_cmd_pkg::CMD_WP);
			pmbus_cmd_pkg::WP_PLUS_RUN:
				wpAllows = (cmdCode == pmbus_cmd_pkg::CMD_WP) ||
					(cmdCode == pmbus_cmd_pkg::CMD_RUN);
			pmbus_cmd_pkg::WP_PLUS_SETUP:
				wpAllows = (cmdCode == pmbus_cmd_pkg::CMD_WP) ||
					(cmdCode == pmbus_cmd_pkg::CMD_RUN) ||
					(cmdCode == pmbus_cmd_pkg::CMD_SRC) ||
					(cmdCode == pmbus_cmd_pkg::CMD_VSET);
			default: wpAllows = 1'b1;
		endcase
	end

	// Data legality of the byte registers with fixed or coded fields
	always_comb begin
		case (cmdCode)
			pmbus_cmd_pkg::CMD_RUN: begin
				dataOk = ((wrData[7:0] & pmbus_cmd_pkg::RUN_FIXED_MASK) ==
					8'h00) && ((wrData[5:4] == 2'b00) ||
					(wrData[5:2] == pmbus_cmd_pkg::MRG_LO_IGN) ||
					(wrData[5:2] == pmbus_cmd_pkg::MRG_LO_ACT) ||
					(wrData[5:2] == pmbus_cmd_pkg::MRG_HI_IGN) ||
					(wrData[5:2] == pmbus_cmd_pkg::MRG_HI_ACT));
			end
			pmbus_cmd_pkg::CMD_SRC: begin
				dataOk = (wrData[7:0] & pmbus_cmd_pkg::SRC_FIXED_MASK) ==
					pmbus_cmd_pkg::SRC_FIXED_VAL;
			end
			pmbus_cmd_pkg::CMD_WP: begin
				dataOk = (wrData[7:0] == pmbus_cmd_pkg::WP_ONLY_SELF) ||
					(wrData[7:0] == pmbus_cmd_pkg::WP_PLUS_RUN) ||
					(wrData[7:0] == pmbus_cmd_pkg::WP_PLUS_SETUP) ||
					(wrData[7:0] == pmbus_cmd_pkg::WP_OPEN);
			end
			default: dataOk = 1'b1;
		endcase
	end

	// Byte count must match the class of a write
	always_comb begin
		case (kind)
			pmbus_cmd_pkg::KIND_BYTE_RW: cntOk = (wrByteCnt == 2'd1);
			pmbus_cmd_pkg::KIND_WORD_RW: cntOk = (wrByteCnt == 2'd2);
			pmbus_cmd_pkg::KIND_SEND: cntOk = (wrByteCnt == 2'd0);
			default: cntOk = 1'b0;
		endcase
	end

	assign pecFail = pecChecked && !pecGood;
	assign isWrite = clkEn && cmdStrobe && cmdWrite;
	assign wrongDir = cmdWrite ?
		(kind == pmbus_cmd_pkg::KIND_BYTE_RO) ||
		(kind == pmbus_cmd_pkg::KIND_WORD_RO) :
		(kind == pmbus_cmd_pkg::KIND_SEND);
	// Writes that fail the lock (except clear), the data or the packet check change nothing
	assign doWrite = isWrite && wpAllows && dataOk && cntOk && !pecFail &&
		((kind == pmbus_cmd_pkg::KIND_BYTE_RW) ||
		(kind == pmbus_cmd_pkg::KIND_WORD_RW));
	assign doClear = isWrite && cntOk && !pecFail &&
		(cmdCode == pmbus_cmd_pkg::CMD_CLR);
	assign doSave = isWrite && cntOk && !pecFail && wpAllows &&
		(cmdCode == pmbus_cmd_pkg::CMD_SAVE);
	assign doLoad = isWrite && cntOk && !pecFail && wpAllows &&
		(cmdCode == pmbus_cmd_pkg::CMD_LOAD);

	// -----------------------------------------------------------------
	// Operating registers
	// -----------------------------------------------------------------
	// Run, margin targets; the run byte is volatile and not reloaded
	always_ff @(posedge mclk) begin
		if (srst) begin
			runReg_r <= pmbus_cmd_pkg::RUN_RST;
			vhiReg_r <= pmbus_cmd_pkg::VHI_RST;
			vloReg_r <= pmbus_cmd_pkg::VLO_RST;
		end else if (doWrite) begin
			if (cmdCode == pmbus_cmd_pkg::CMD_RUN)
				runReg_r <= wrData[7:0];
			if (cmdCode == pmbus_cmd_pkg::CMD_VHI)
				vhiReg_r <= wrData;
			if (cmdCode == pmbus_cmd_pkg::CMD_VLO)
				vloReg_r <= wrData;
		end
	end

	// Saved registers: a reload takes the stored copy
	always_ff @(posedge mclk) begin
		if (srst) begin
			srcReg_r <= pmbus_cmd_pkg::SRC_RST;
			wpReg_r <= pmbus_cmd_pkg::WP_RST;
			vsetReg_r <= pmbus_cmd_pkg::VSET_RST;
		end else if (doLoad) begin
			srcReg_r <= nvSrc_r;
			wpReg_r <= nvWp_r;
			vsetReg_r <= nvVset_r;
		end else if (doWrite) begin
			if (cmdCode == pmbus_cmd_pkg::CMD_SRC)
				srcReg_r <= wrData[7:0];
			if (cmdCode == pmbus_cmd_pkg::CMD_WP)
				wpReg_r <= wrData[7:0];
			if (cmdCode == pmbus_cmd_pkg::CMD_VSET)
				vsetReg_r <= wrData;
		end
	end

	// Default store; flip-flops stand in for the non-volatile array, so
	// its contents return to defaults on reset
	always_ff @(posedge mclk) begin
		if (srst) begin
			nvSrc_r <= pmbus_cmd_pkg::SRC_RST;
			nvWp_r <= pmbus_cmd_pkg::WP_RST;
			nvVset_r <= pmbus_cmd_pkg::VSET_RST;
		end else if (doSave) begin
			nvSrc_r <= srcReg_r;
			nvWp_r <= wpReg_r;
			nvVset_r <= vsetReg_r;
		end
	end

	// Manufacturer bytes and their stored copies, one slice per entry
	generate
		for (g = 0; g < pmbus_cmd_pkg::MFR_COUNT; g++) begin : gMfr
			always_ff @(posedge mclk) begin
				if (srst) begin
					mfrReg_r[g] <= pmbus_cmd_pkg::MFR_RST;
					nvMfr_r[g] <= pmbus_cmd_pkg::MFR_RST;
				end else begin
					if (doLoad)
						mfrReg_r[g] <= nvMfr_r[g];
					else if (doWrite && mfrHit[g])
						mfrReg_r[g] <= wrData[7:0];
					if (doSave)
						nvMfr_r[g] <= mfrReg_r[g];
				end
			end
		end
	endgenerate

	// -----------------------------------------------------------------
	// Status flags
	// -----------------------------------------------------------------
	// Fault flags are sticky; a new event beats a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (srst) begin
			voutSt_r <= 4'h0;
			ioutSt_r <= 4'h0;
			vddSt_r <= 1'b0;
			tempSt_r <= 1'b0;
		end else if (clkEn) begin
			voutSt_r <= (doClear ? 4'h0 : voutSt_r) | voutEvS;
			ioutSt_r <= (doClear ? 4'h0 : ioutSt_r) |
				{ioutEvS[2:1], 1'b0, ioutEvS[0]};
			vddSt_r <= (!doClear && vddSt_r) | vddUvS;
			tempSt_r <= (!doClear && tempSt_r) | overTempS;
		end
	end

	// Bus error flags; errors of the clearing transaction itself survive
	always_ff @(posedge mclk) begin
		if (srst) begin
			badCmd_r <= 1'b0;
			badData_r <= 1'b0;
			pecOk_r <= 1'b0;
		end else if (clkEn) begin
			badCmd_r <= (!doClear && badCmd_r) || (cmdStrobe &&
				((kind == pmbus_cmd_pkg::KIND_NONE) || wrongDir));
			badData_r <= (!doClear && badData_r) || (isWrite &&
				(kind != pmbus_cmd_pkg::KIND_NONE) && !wrongDir &&
				(!dataOk || !cntOk || (!wpAllows &&
				(cmdCode != pmbus_cmd_pkg::CMD_CLR))));
			if (cmdStrobe && pecChecked)
				pecOk_r <= pecGood;
			else if (doClear)
				pecOk_r <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// Summaries
	// -----------------------------------------------------------------
	logic [7:0] statByte;
	logic [15:0] statWord;
	logic [7:0] statCml;
	logic [7:0] statVout;
	logic [7:0] statIout;

	// Off and power-good-lost are live levels, so clearing cannot touch them
	always_comb begin
		statVout = {voutSt_r, 4'h0};
		statIout = {ioutSt_r, 4'h0};
		statCml = 8'h00;
		statCml[pmbus_cmd_pkg::CML_BADCMD] = badCmd_r;
		statCml[pmbus_cmd_pkg::CML_BADDATA] = badData_r;
		statCml[pmbus_cmd_pkg::CML_PEC] = pecOk_r;
		statByte = 8'h00;
		statByte[pmbus_cmd_pkg::SB_OFF] = !convOn;
		statByte[pmbus_cmd_pkg::SB_VOV] = voutSt_r[pmbus_cmd_pkg::VOUT_OVF];
		statByte[pmbus_cmd_pkg::SB_IOC] = ioutSt_r[pmbus_cmd_pkg::IOUT_OCF];
		statByte[pmbus_cmd_pkg::SB_VDD] = vddSt_r;
		statByte[pmbus_cmd_pkg::SB_TEMP] = tempSt_r;
		statByte[pmbus_cmd_pkg::SB_CML] = badCmd_r || badData_r;
		statWord = {8'h00, statByte};
		statWord[pmbus_cmd_pkg::SW_VOUT] = |voutSt_r;
		statWord[pmbus_cmd_pkg::SW_IOUT] = |ioutSt_r;
		statWord[pmbus_cmd_pkg::SW_VDD] = vddSt_r;
		statWord[pmbus_cmd_pkg::SW_PGL] = pgLostS;
	end

	// -----------------------------------------------------------------
	// Read answer
	// -----------------------------------------------------------------
	logic [15:0] rdMux;
	integer i;

	// Word reads return the full word; byte reads sit in the low byte
	always_comb begin
		rdMux = 16'h0000;
		case (cmdCode)
			pmbus_cmd_pkg::CMD_RUN: rdMux = {8'h00, runReg_r};
			pmbus_cmd_pkg::CMD_SRC: rdMux = {8'h00, srcReg_r};
			pmbus_cmd_pkg::CMD_WP: rdMux = {8'h00, wpReg_r};
			pmbus_cmd_pkg::CMD_FEAT:
				rdMux = {8'h00, pmbus_cmd_pkg::FEATURE_VAL};
			pmbus_cmd_pkg::CMD_FMT:
				rdMux = {8'h00, pmbus_cmd_pkg::FORMAT_VAL};
			pmbus_cmd_pkg::CMD_VSET: rdMux = vsetReg_r;
			pmbus_cmd_pkg::CMD_VHI: rdMux = vhiReg_r;
			pmbus_cmd_pkg::CMD_VLO: rdMux = vloReg_r;
			pmbus_cmd_pkg::CMD_SBYTE: rdMux = {8'h00, statByte};
			pmbus_cmd_pkg::CMD_SWORD: rdMux = statWord;
			pmbus_cmd_pkg::CMD_SVOUT: rdMux = {8'h00, statVout};
			pmbus_cmd_pkg::CMD_SIOUT: rdMux = {8'h00, statIout};
			pmbus_cmd_pkg::CMD_SCML: rdMux = {8'h00, statCml};
			pmbus_cmd_pkg::CMD_IDENT: rdMux = pmbus_cmd_pkg::IDENT_WORD;
			default: begin
				for (i = 0; i < pmbus_cmd_pkg::MFR_COUNT; i++) begin
					if (mfrHit[i])
						rdMux = {8'h00, mfrReg_r[i]};
				end
			end
		endcase
	end

	// Answer one cycle after a read strobe; unreadable codes are refused
	always_ff @(posedge mclk) begin
		if (srst) begin
			rdValid <= 1'b0;
			rdAck <= 1'b0;
			rdData <= 16'h0000;
		end else if (clkEn) begin
			rdValid <= cmdStrobe && !cmdWrite;
			if (cmdStrobe && !cmdWrite) begin
				rdAck <= (kind != pmbus_cmd_pkg::KIND_NONE) && !wrongDir;
				rdData <= rdMux;
			end
		end
	end

	// -----------------------------------------------------------------
	// Converter control
	// -----------------------------------------------------------------
	logic runReq;
	logic onNxt;
	logic [1:0] mrgNxt;

	// Turn-on source per the two writable source bits
	always_comb begin
		runReq = runReg_r[pmbus_cmd_pkg::RUN_ON_BIT];
		case ({srcReg_r[pmbus_cmd_pkg::SRC_CMD_BIT],
			srcReg_r[pmbus_cmd_pkg::SRC_PIN_BIT]})
			2'b00: onNxt = 1'b1;
			2'b01: onNxt = enPinS;
			2'b10: onNxt = runReq;
			default: onNxt = runReq && enPinS;
		endcase
		// Margin only matters while on: 01 low, 10 high
		case (runReg_r[5:2])
			pmbus_cmd_pkg::MRG_LO_IGN, pmbus_cmd_pkg::MRG_LO_ACT:
				mrgNxt = onNxt ? 2'b01 : 2'b00;
			pmbus_cmd_pkg::MRG_HI_IGN, pmbus_cmd_pkg::MRG_HI_ACT:
				mrgNxt = onNxt ? 2'b10 : 2'b00;
			default: mrgNxt = 2'b00;
		endcase
	end

	// Registered controls so the power stage never sees decode glitches
	always_ff @(posedge mclk) begin
		if (srst) begin
			convOn <= 1'b0;
			marginSel <= 2'b00;
			marginActOnFault <= 1'b0;
			vrefTarget <= pmbus_cmd_pkg::VSET_RST;
		end else if (clkEn) begin
			convOn <= onNxt;
			marginSel <= mrgNxt;
			marginActOnFault <= (mrgNxt != 2'b00) && runReg_r[3];
			case (mrgNxt)
				2'b01: vrefTarget <= vloReg_r;
				2'b10: vrefTarget <= vhiReg_r;
				default: vrefTarget <= vsetReg_r;
			endcase
		end
	end

	// Manufacturer settings to the analog side; scratch bytes D0 and D3 go nowhere
	assign delaySetting = mfrReg_r[1];
	assign freqSetting = mfrReg_r[2];
	assign loopOffsetSetting = mfrReg_r[4];
	assign lockoutSetting = mfrReg_r[5];
	assign trackSetting = mfrReg_r[6];

	// Alert pulls low while any fault flag is held; clear releases it
	always_ff @(posedge mclk) begin
		if (srst)
			alertOe <= 1'b0;
		else if (clkEn)
			alertOe <= !doClear && ((|voutSt_r) || (|ioutSt_r) || vddSt_r ||
				tempSt_r || badCmd_r || badData_r);
	end
	assign alertOut = 1'b0;
endmodule

/* testbench/pmbus_command_decoder_assertions.sv */
/* Port checker for the command decoder.
 Assumes the unused supply and temperature fault inputs stay low. */
`timescale 1ns/10ps
module pmbus_decoder_checker (
	// Clock, reset, freeze
	input wire logic mclk,
	input wire logic srst,
	input wire logic clkEn,
	// Transaction and fault sources
	input wire logic cmdStrobe,
	input wire logic cmdWrite,
	input wire logic [7:0] cmdCode,
	input wire logic [3:0] voutFaultEv,
	input wire logic power_good_lost_flag,
	// Answers and alert
	input wire logic rdValid,
	input wire logic rdAck,
	input wire logic [15:0] rdData,
	input wire logic alertOe
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	// Strobes taken at this edge; quiet means no source raising a flag
	wire logic rdTk = cmdStrobe && clkEn && !cmdWrite;
	wire logic clrTk = cmdStrobe && clkEn && cmdWrite && cmdCode == 8'h03;
	wire logic quiet = voutFaultEv == 4'h0 && !power_good_lost_flag;
	// ------------------------------------------------------------
	// Read answers and alert clear
	// ------------------------------------------------------------
	AST_READ_ANSWER: assert property (rdTk |=> rdValid)
		else $error("read not answered");
	AST_NO_STRAY: assert property (!rdTk |=> !rdValid)
		else $error("stray read answer");
	AST_RD_HOLD: assert property (!rdValid |-> $stable(rdData))
		else $error("read data moved");
	AST_FEATURE: assert property (rdTk && cmdCode == 8'h19 |=>
		rdAck && rdData == 16'h00D0) else $error("feature byte wrong");
	AST_FORMAT: assert property (rdTk && cmdCode == 8'h20 |=>
		rdAck && rdData == 16'h0017) else $error("format byte wrong");
	AST_IDENT: assert property (rdTk && cmdCode == 8'hFC |=> rdAck)
		else $error("identity refused");
	AST_BAD_CODE: assert property (rdTk && cmdCode == 8'h00 |=> !rdAck)
		else $error("unknown code answered");
	AST_CLEAR: assert property (quiet[*4] ##0 clrTk |-> ##2 !alertOe)
		else $error("alert kept after clear");
	// Main scenarios reached
	cover property (clrTk);
	cover property (rdValid && !rdAck);
	cover property ($rose(alertOe));
endmodule
bind pmbus_command_decoder pmbus_decoder_checker u_chk (.mclk(mclk),
	.srst(srst), .clkEn(clkEn), .cmdStrobe(cmdStrobe), .cmdWrite(cmdWrite),
	.cmdCode(cmdCode), .voutFaultEv(voutFaultEv), .rdValid(rdValid),
	.power_good_lost_flag(power_good_lost_flag), .rdAck(rdAck),
	.rdData(rdData), .alertOe(alertOe));

/* testbench/pmbus_host_model.sv */
/* Host side: hands one finished transaction per strobe to the decoder.
 Assumes it is driven from the bench clock. */
`timescale 1ns/10ps
module pmbus_host_model (
	// Clock
	input wire logic mclk,
	// Transaction toward the decoder
	output logic cmdStrobe,
	output logic cmdWrite,
	output logic [7:0] cmdCode,
	output logic [1:0] wrByteCnt,
	output logic [15:0] wrData,
	output logic pecChecked,
	output logic pecGood
);
	initial {cmdStrobe, cmdWrite, cmdCode, wrByteCnt, wrData} = '0;
	initial {pecChecked, pecGood} = 2'b00;
	// Strobe held one edge; code and data scrambled after, not left stale
	task automatic xfer(input logic w, input logic [7:0] c,
		input logic [1:0] n, input logic [15:0] d, input logic [1:0] p);
		@(posedge mclk);
		#1;
		{cmdStrobe, cmdWrite, cmdCode, wrByteCnt, wrData} = {1'b1, w, c, n, d};
		{pecChecked, pecGood} = p;
		@(posedge mclk);
		#1;
		{cmdStrobe, cmdCode, wrData} = {1'b0, ~c, ~d};
	endtask
endmodule

/* testbench/tb_pmbus_command_decoder.sv */
/* Self-checking bench for the command decoder.
 Assumes the host model and the bound port checker. */
`timescale 1ns/10ps
module tb_pmbus_command_decoder;
	typedef struct {logic a; logic [15:0] d; logic [15:0] m;} exp_s;
	logic mclk = 0, srst = 1, enPin = 0, pgl = 0, cmdStrobe, cmdWrite;
	logic [3:0] vEv = 0;
	logic [7:0] cmdCode, wc [3] = '{8'h21, 8'h25, 8'h26};
	logic [1:0] wrByteCnt, run;
	logic [15:0] wrData, rdData, vref, wv [3];
	logic [7:0] mv [3], dly, frq, lck, lof, trk;
	logic pecChecked, pecGood, rdValid, rdAck, alertOe, convOn, act;
	logic ce = 1'b1, aOut;
	logic [31:0] s = 32'hD07FA61E;
	int errCount = 0, samplesChecked = 0, i;
	exp_s expQ [$], e;
	always #4 mclk = ~mclk;
	pmbus_host_model u_host (.mclk(mclk), .cmdStrobe(cmdStrobe),
		.cmdWrite(cmdWrite), .cmdCode(cmdCode), .wrByteCnt(wrByteCnt),
		.wrData(wrData), .pecChecked(pecChecked), .pecGood(pecGood));
	pmbus_command_decoder u_dut (.mclk(mclk), .srst(srst), .clkEn(ce),
		.cmdStrobe(cmdStrobe), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
		.wrByteCnt(wrByteCnt), .wrData(wrData), .pecChecked(pecChecked),
		.pecGood(pecGood), .rdValid(rdValid), .rdAck(rdAck),
		.rdData(rdData), .enPin(enPin), .voutFaultEv(vEv),
		.ioutFaultEv({vEv[3], 2'b00}), .vddUvEv(1'b0), .overTempEv(1'b0),
		.power_good_lost_flag(pgl), .alertOut(aOut), .alertOe(alertOe),
		.convOn(convOn), .marginSel(run), .marginActOnFault(act),
		.vrefTarget(vref), .delaySetting(dly), .freqSetting(frq),
		.lockoutSetting(lck), .loopOffsetSetting(lof), .trackSetting(trk));
	// Answers checked against the oldest note
	always @(negedge mclk) if (rdValid === 1'b1) begin
		e = expQ.pop_front();
		chk({15'h0, rdAck, rdData & e.m}, {15'h0, e.a, e.d & e.m});
	end
	// Xorshift step for the random write data
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		samplesChecked++;
		if (g !== x) begin
			errCount++;
			$display("mismatch %0t got %h want %h", $time, g, x);
		end
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		u_host.xfer(1'b1, c, (c < 8'h04 || c == 8'h10 || c > 8'hCF) ?
			((c == 8'h03) ? 2'd0 : 2'd1) : ((c > 8'h10 && c < 8'h13) ?
			2'd0 : 2'd2), d, 2'b00);
	endtask
	task automatic rd(input logic [7:0] c, input logic a,
		input logic [15:0] d, input logic [15:0] m);
		expQ.push_back('{a, d, m});
		u_host.xfer(1'b0, c, 2'd0, 16'h0000, 2'b00);
	endtask
	// Pin level, then the synced result on the run output
	task automatic pin(input logic p, input logic x);
		enPin = p;
		repeat (6) @(posedge mclk);
		#1;
		chk({31'h0, convOn}, {31'h0, x});
	endtask
	task automatic op(input logic [7:0] b, input logic [3:0] x,
		input logic [15:0] v);
		wr(8'h01, {8'h00, b});
		repeat (3) @(posedge mclk);
		#1;
		chk({convOn, run, act, vref}, {x, v});
	endtask
	task automatic endOfTest;
		if (errCount == 0 && samplesChecked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		errCount++;
		endOfTest();
	end
	initial begin
		repeat (2) @(posedge mclk);
		#1 srst = 0;
		rd(8'h02, 1, 16'h0017, 16'hFFFF);
		rd(8'h19, 1, 16'h00D0, 16'hFFFF);
		rd(8'h20, 1, 16'h0017, 16'hFFFF);
		rd(8'hFC, 1, pmbus_cmd_pkg::IDENT_WORD, 16'hFFFF);
		for (i = 0; i < 3; i++) begin
			s = xs(s);
			wv[i] = 16'h0133 + {8'h00, s[7:0]};
			mv[i] = s[15:8];
			wr(wc[i], wv[i]);
			rd(wc[i], 1, wv[i], 16'hFFFF);
			wr(8'hD1 + i[7:0], {8'h00, s[15:8]});
			rd(8'hD1 + i[7:0], 1, {8'h00, s[15:8]}, 16'hFFFF);
		end
		chk({dly, frq, lck, lof}, {mv[0], mv[1], 16'h0000});
		chk({24'h0, trk}, 32'h0);
		wr(8'h02, 16'h001B);
		op(8'h80, 4'h8, wv[0]);
		op(8'h94, 4'hA, wv[2]);
		op(8'hA8, 4'hD, wv[1]);
		op(8'h00, 4'h0, wv[0]);
		wr(8'h02, 16'h0017);
		pin(1, 1);
		pin(0, 0);
		wr(8'h02, 16'h001F);
		op(8'h80, 4'h0, wv[0]);
		pin(1, 1);
		wr(8'h10, 16'h0080);
		wr(8'hD0, 16'h00A5);
		rd(8'hD0, 1, 16'h0000, 16'hFFFF);
		rd(8'h7E, 1, 16'h0040, 16'h0040);
		wr(8'h10, 16'h0040);
		op(8'h00, 4'h0, wv[0]);
		wr(8'h10, 16'h0020);
		wr(8'h21, 16'h0200);
		wr(8'h25, 16'h0150);
		rd(8'h21, 1, 16'h0200, 16'hFFFF);
		rd(8'h25, 1, wv[1], 16'hFFFF);
		wr(8'h10, 16'h0000);
		rd(8'h00, 0, 16'h0000, 16'h0000);
		rd(8'h7E, 1, 16'h0080, 16'h0080);
		u_host.xfer(1, 8'hD0, 1, 16'h0033, 2'b10);
		rd(8'h7E, 1, 16'h0000, 16'h0020);
		u_host.xfer(1, 8'hD0, 1, 16'h0011, 2'b11);
		rd(8'h7E, 1, 16'h0020, 16'h0020);
		wr(8'h11, 16'h0000);
		wr(8'hD0, 16'h0022);
		wr(8'h12, 16'h0000);
		rd(8'hD0, 1, 16'h0011, 16'hFFFF);
		@(posedge mclk);
		#1 ce = 1'b0;
		wr(8'hD0, 16'h0055);
		ce = 1'b1;
		rd(8'hD0, 1, 16'h0011, 16'hFFFF);
		vEv = 4'h8;
		repeat (3) @(posedge mclk);
		#1 vEv = 4'h0;
		repeat (4) @(posedge mclk);
		chk({30'h0, aOut, alertOe}, 32'h1);
		rd(8'h7A, 1, 16'h0080, 16'h0080);
		rd(8'h7B, 1, 16'h0080, 16'h0080);
		rd(8'h78, 1, 16'h0030, 16'h0030);
		wr(8'h03, 16'h0000);
		repeat (2) @(posedge mclk);
		chk({31'h0, alertOe}, 32'h0);
		rd(8'h7A, 1, 16'h0000, 16'hFFFF);
		pgl = 1;
		wr(8'h03, 16'h0000);
		rd(8'h79, 1, 16'h0840, 16'h0840);
		repeat (4) @(posedge mclk);
		endOfTest();
	end
endmodule
